// >>> bench/adc_ctrl_assertions.sv
`timescale 1ns/1ns

// Port-level checks of the converter control block.
module adc_ctrl_checker (
    // Clock and reset.
    input wire        sys_clk_i,
    input wire        rst_i,
    // Inputs that feed the pin override.
    input wire [3:0]  port_dir_input_i,
    input wire [3:0]  pullup_request_i,
    // Bus answers.
    input wire [31:0] hrdata_o,
    input wire        hreadyout_o,
    input wire        hresp_o,
    // Converter and pin outputs.
    input wire        analog_power_o,
    input wire        sample_track_o,
    input wire        ref_from_pin_o,
    input wire [3:0]  pin_dir_input_o,
    input wire [3:0]  pin_pullup_o,
    input wire [3:0]  pin_digital_off_o,
    input wire        ref_pin_claim_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Pin outputs lag by one clock, so the edge after reset is skipped.
    a_dir_override: assert property (!$past(rst_i) |->
        pin_dir_input_o == ($past(port_dir_input_i) | pin_digital_off_o))
        else $error("pin direction ignores analog enable");
    a_pullup_cut: assert property (!$past(rst_i) |->
        pin_pullup_o == ($past(pullup_request_i) & ~pin_digital_off_o))
        else $error("pull-up left on an analog pin");
    a_ref_claim: assert property (!$past(rst_i) |->
        ref_pin_claim_o == ref_from_pin_o)
        else $error("reference pin claim does not follow select");
    a_pins_reset: assert property ($past(rst_i) |-> pin_digital_off_o == 4'hf)
        else $error("pins not analog after reset");
    a_sample_powered: assert property (sample_track_o |-> analog_power_o)
        else $error("sampling while powered off");
    a_sample_len: assert property ($rose(sample_track_o) |-> sample_track_o [*2])
        else $error("sample phase too short");
    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    a_ready_after: assert property (!$past(rst_i) |-> hreadyout_o)
        else $error("bus stalled after reset");
    a_rdata_upper: assert property (hrdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ns

module tb_top;
    reg         sys_clk_i = 1'b0;       // System clock, 40 ns.
    reg         rst_i = 1'b1;           // Synchronous reset.
    reg         hsel_i = 1'b0;          // Bus request signals.
    reg  [7:0]  haddr_i = 8'h00;
    reg  [1:0]  htrans_i = 2'h0;
    reg         hwrite_i = 1'b0;
    reg  [2:0]  hsize_i = 3'h2;
    reg  [31:0] hwdata_i = 32'h0;
    reg  [3:0]  port_dir_input_i = 4'h0; // Port block settings.
    reg  [3:0]  pullup_request_i = 4'h0;
    reg         comparator_i = 1'b0;    // Stands in for the analog comparator.
    wire [31:0] hrdata_o;
    wire        hreadyout_o, hresp_o, analog_power_o, sample_track_o, ref_from_pin_o;
    wire        ref_pin_claim_o, conv_irq_o;
    wire [11:0] dac_code_o;
    wire [2:0]  channel_select_o;
    wire [3:0]  pin_dir_input_o, pin_pullup_o, pin_digital_off_o;
    integer     error_cnt = 0;          // Mismatches seen.
    integer     n_checks = 0;           // Comparisons made.
    integer     cyc = 0;                // Free cycle count for timing.
    reg  [31:0] rd;                     // Last read data.

    // The single slave's ready is the bus's ready.
    adc_conversion_control DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .port_dir_input_i(port_dir_input_i),
        .pullup_request_i(pullup_request_i), .comparator_i(comparator_i),
        .analog_power_o(analog_power_o), .sample_track_o(sample_track_o),
        .dac_code_o(dac_code_o), .channel_select_o(channel_select_o),
        .ref_from_pin_o(ref_from_pin_o), .pin_dir_input_o(pin_dir_input_o),
        .pin_pullup_o(pin_pullup_o), .pin_digital_off_o(pin_digital_off_o),
        .ref_pin_claim_o(ref_pin_claim_o), .conv_irq_o(conv_irq_o));

    // Clock and cycle counter.
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
    end

    // Prints the counts and the verdict, then stops.
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // Compares one value with its expectation.
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Waits for hready sampled at a rising edge; read data is taken at that edge.
    task wait_ready;
        reg     ok;
        integer k;
        begin
            ok = 1'b0;
            k = 0;
            while (!ok) begin
                @(posedge sys_clk_i);
                ok = (hreadyout_o === 1'b1);
                rd = hrdata_o;
                k = k + 1;
                if (k > 50) begin
                    error_cnt = error_cnt + 1;
                    $display("wrong value at %0t: bus hang", $time);
                    end_of_test;
                end
            end
        end
    endtask

    // One single-word transfer: address phase, then data phase.
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk_i);
            hsel_i <= 1'b1;
            haddr_i <= a;
            hwrite_i <= w;
            htrans_i <= 2'h2;
            wait_ready;
            hsel_i <= 1'b0;
            htrans_i <= 2'h0;
            hwdata_i <= d;
            wait_ready;
        end
    endtask

    // Reads a register and compares the masked bits.
    task rd_chk(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk(rd & m, e);
        end
    endtask

    // Reset state: converter off, every shared pin analog.
    task t_reset;
        begin
            rd_chk(8'h00, 32'h60, 32'h20);
            chk(analog_power_o, 1'b0);
            rd_chk(8'h08, 32'hf, 32'hf);
        end
    endtask

    // Analog enables override direction, pull-ups and digital use.
    task t_pins;
        begin
            port_dir_input_i <= 4'h2;
            pullup_request_i <= 4'hf;
            bus(1'b1, 8'h08, 32'h5);
            repeat (3) @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            chk(pin_dir_input_o, 4'h7);
            chk(pin_pullup_o, 4'ha);
            chk(pin_digital_off_o, 4'h5);
        end
    endtask

    // Channel bits from both registers, reference pin, power on.
    task t_route;
        begin
            bus(1'b1, 8'h04, 32'hc0);
            bus(1'b1, 8'h00, 32'h03);
            repeat (2) @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            chk(channel_select_o, 3'h7);
            chk({ref_from_pin_o, ref_pin_claim_o}, 2'h3);
            chk(analog_power_o, 1'b1);
        end
    endtask

    // A whole conversion with a given divider, comparator level and enables.
    task t_conv(input [2:0] dv, input cmp, input [2:0] ie, input [11:0] res);
        integer t0;
        integer k;
        begin
            bus(1'b1, 8'h04, {29'h0, dv});
            bus(1'b1, 8'h14, {29'h0, ie});
            comparator_i <= cmp;
            bus(1'b1, 8'h00, 32'h80);
            repeat (4) @(posedge sys_clk_i);
            rd_chk(8'h00, 32'h40, 32'h40);
            bus(1'b1, 8'h00, 32'h00);
            t0 = cyc;
            k = 0;
            rd = 32'h40;
            while (rd[6] && k < 300) begin
                bus(1'b0, 8'h00, 32'h0);
                k = k + 1;
            end
            if (rd[6]) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: conversion hang", $time);
                end_of_test;
            end
            t0 = cyc - t0;
            chk(t0 >= (16 << dv) && t0 <= (16 << dv) + (1 << dv) + 12, 1);
            rd_chk(8'h0c, 32'hff, {24'h0, res[7:0]});
            rd_chk(8'h10, 32'hf, {28'h0, res[11:8]});
            rd_chk(8'h14, 32'h4, 32'h4);
            chk(conv_irq_o, ie == 3'h3);
            chk(dac_code_o, {20'h0, res});
            bus(1'b1, 8'h00, 32'h80);
            rd_chk(8'h0c, 32'hff, {24'h0, res[7:0]});
            bus(1'b1, 8'h00, 32'h20);
            @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            chk(analog_power_o, 1'b0);
        end
    endtask

    // Main sequence; dividers 16 and 32 keep the conversion period above its
    // minimum at 25 MHz; interrupt enabled then masked.
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_pins;
        t_route;
        t_conv(3'h4, 1'b1, 3'h3, 12'hfff);
        t_conv(3'h5, 1'b0, 3'h0, 12'h000);
        end_of_test;
    end
endmodule

bind adc_conversion_control adc_ctrl_checker u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .port_dir_input_i(port_dir_input_i), .pullup_request_i(pullup_request_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .analog_power_o(analog_power_o), .sample_track_o(sample_track_o),
    .ref_from_pin_o(ref_from_pin_o), .pin_dir_input_o(pin_dir_input_o),
    .pin_pullup_o(pin_pullup_o), .pin_digital_off_o(pin_digital_off_o),
    .ref_pin_claim_o(ref_pin_claim_o));

// >>> hdl/adc_conversion_control.v
// Notes on behaviour
// - Analog power on only while power-off bit clear.
// - Reference select picks supply or reference pin.
// - Pin enable makes pin analog, digital off.
// - Pull-ups disconnected on analog-enabled pins.
// - Analog enable overrides port direction setting.
// - Three channel bits across both control registers.
// - Conversion clock divided per three-bit field.
// - Interrupt needs global and converter enables.
// - Start bit low-high-low begins a conversion.
// - Pending falls, then result bytes hold value.
// - Conversion takes sixteen conversion clock periods.
// - Reset leaves shared pins as analog inputs.
// - Result is 12-bit unsigned, reference over 4096.
// - Start held high resets converter, sets pending.
// - Completion clears pending, sets request flag.
// - Divider codes give divide 1 through 64.
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`include "adc_ctrl_defines.vh"

module adc_conversion_control (
    // Clock and reset.
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // AHB-Lite slave.
    input  wire        hsel_i,
    input  wire [7:0]  haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    // Port settings from the I/O block.
    input  wire [3:0]  port_dir_input_i,
    input  wire [3:0]  pullup_request_i,
    // Analog front end.
    input  wire        comparator_i,
    output reg         analog_power_o,
    output reg         sample_track_o,
    output reg  [11:0] dac_code_o,
    output reg  [2:0]  channel_select_o,
    output reg         ref_from_pin_o,
    // Effective pin configuration.
    output wire [3:0]  pin_dir_input_o,
    output wire [3:0]  pin_pullup_o,
    output wire [3:0]  pin_digital_off_o,
    output wire        ref_pin_claim_o,
    // Interrupt request to the core.
    output reg         conv_irq_o
);

    // Sequencer states.
    localparam [1:0] ST_IDLE = 2'h0;   // Waiting for a start sequence.
    localparam [1:0] ST_HELD = 2'h1;   // Start bit high, converter held in reset.
    localparam [1:0] ST_CONV = 2'h2;   // Conversion running.

    // Software-visible control state.
    reg        start_q;                // Start bit as last written.
    reg        power_off_q;            // Converter power-off bit.
    reg        chan_hi_q;              // Channel select, top bit.
    reg        chan_mid_q;             // Channel select, middle bit.
    reg        chan_lo_q;              // Channel select, low bit.
    reg        ref_select_q;           // High selects the reference pin.
    reg [2:0]  divider_q;              // Conversion clock divider code.
    reg [3:0]  pin_enable_q;           // Per-pin analog input enables.
    reg        global_ie_q;            // Global interrupt enable.
    reg        conv_ie_q;              // Converter interrupt enable.
    reg        conv_req_q;             // Converter interrupt request flag.
    reg        pending_q;              // Conversion pending flag.
    reg [11:0] result_q;               // Last completed conversion value.

    // Sequencer state.
    reg [1:0]  state_q;                // Current sequencer state.
    reg [4:0]  period_q;               // Conversion clock periods elapsed.
    reg [11:0] sar_q;                  // Successive approximation trial value.
    reg [3:0]  bit_q;                  // Bit under trial.

    // Bus data phase tracking.
    reg        wr_pending_q;           // A write awaits its data phase.
    reg [7:0]  wr_addr_q;              // Address of that write.

    // Comparator synchroniser and filtered level.
    reg        comp_s1_q;              // First stage, read only by the second.
    reg        comp_s2_q;              // Second stage.
    reg        comp_s3_q;              // Third stage.
    reg        comp_q;                 // Accepted comparator level.

    wire       conv_tick;              // One pulse per conversion clock period.
    wire       div_restart;            // Realigns the divider at conversion start.
    wire       addr_phase;             // A valid transfer is being offered.
    wire       start_wr;               // Write of control_a in its data phase.
    wire       new_start;              // Start bit value being written.
    wire       finish;                 // Last period of a conversion ends now.
    wire       begin_conv;             // Start bit falls after having risen.

    // Matches a byte address against a register offset on word granularity.
    function hits;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hits = (addr[7:2] == offset[7:2]);
        end
    endfunction

    assign addr_phase  = hsel_i && hready_i && (htrans_i == `HTRANS_NONSEQ);
    assign start_wr    = wr_pending_q && hits(wr_addr_q, `OFS_CONTROL_A);
    assign new_start   = hwdata_i[`BIT_START];
    assign begin_conv  = (state_q == ST_HELD) && start_wr && !new_start;
    assign finish      = (state_q == ST_CONV) && conv_tick
                         && (period_q == `CONV_PERIODS - 5'h01);
    assign div_restart = (state_q != ST_CONV);

    // Conversion clock source.
    conv_clock_divider u_div (
        .sys_clk_i      (sys_clk_i),
        .rst_i          (rst_i),
        .restart_i      (div_restart),
        .divider_code_i (divider_q),
        .tick_o         (conv_tick)
    );

    // Pin function override.
    pin_function_mux u_pins (
        .sys_clk_i         (sys_clk_i),
        .rst_i             (rst_i),
        .analog_enable_i   (pin_enable_q),
        .port_dir_input_i  (port_dir_input_i),
        .pullup_request_i  (pullup_request_i),
        .ref_select_i      (ref_select_q),
        .pin_dir_input_o   (pin_dir_input_o),
        .pin_pullup_o      (pin_pullup_o),
        .pin_digital_off_o (pin_digital_off_o),
        .ref_pin_claim_o   (ref_pin_claim_o)
    );

    // Comparator comes from the analog side, so it passes three flops and a
    // change is taken only once the last two stages agree.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
            comp_s3_q <= 1'b0;
            comp_q    <= 1'b0;
        end else begin
            comp_s1_q <= comparator_i;
            comp_s2_q <= comp_s1_q;
            comp_s3_q <= comp_s2_q;
            if (comp_s2_q == comp_s3_q) begin
                comp_q <= comp_s3_q;
            end
        end
    end

    // Bus responses: zero wait states and always OKAY.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            hreadyout_o  <= 1'b0;
            hresp_o      <= 1'b0;
            wr_pending_q <= 1'b0;
            wr_addr_q    <= 8'h00;
        end else begin
            hreadyout_o  <= 1'b1;
            hresp_o      <= 1'b0;
            wr_pending_q <= addr_phase && hwrite_i;
            if (addr_phase) begin
                wr_addr_q <= haddr_i;
            end
        end
    end

    // Read data is prepared in the address phase so it stands through the
    // data phase; unmapped addresses read as zero.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0;
        end else if (addr_phase && !hwrite_i) begin
            hrdata_o <= 32'h0;
            if (hits(haddr_i, `OFS_CONTROL_A)) begin
                hrdata_o[`BIT_START]     <= start_q;
                hrdata_o[`BIT_PENDING]   <= pending_q;
                hrdata_o[`BIT_POWER_OFF] <= power_off_q;
                hrdata_o[`BIT_CHAN_MID]  <= chan_mid_q;
                hrdata_o[`BIT_CHAN_LO]   <= chan_lo_q;
            end else if (hits(haddr_i, `OFS_CONTROL_B)) begin
                hrdata_o[`BIT_CHAN_HI]          <= chan_hi_q;
                hrdata_o[`BIT_REF_SELECT]       <= ref_select_q;
                hrdata_o[`DIV_MSB:`DIV_LSB]     <= divider_q;
            end else if (hits(haddr_i, `OFS_PIN_ENABLE_LOW)) begin
                hrdata_o[3:0] <= pin_enable_q;
            end else if (hits(haddr_i, `OFS_RESULT_LOW)) begin
                hrdata_o[7:0] <= result_q[7:0];
            end else if (hits(haddr_i, `OFS_RESULT_HIGH)) begin
                hrdata_o[3:0] <= result_q[11:8];
            end else if (hits(haddr_i, `OFS_IRQ_CONTROL)) begin
                hrdata_o[`BIT_GLOBAL_IE] <= global_ie_q;
                hrdata_o[`BIT_CONV_IE]   <= conv_ie_q;
                hrdata_o[`BIT_CONV_REQ]  <= conv_req_q;
            end
        end
    end

    // Control register writes, taken in the data phase.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            start_q      <= 1'b0;
            power_off_q  <= `RST_POWER_OFF;
            chan_hi_q    <= 1'b0;
            chan_mid_q   <= 1'b0;
            chan_lo_q    <= 1'b0;
            ref_select_q <= 1'b0;
            divider_q    <= `RST_DIVIDER;
            pin_enable_q <= `RST_PIN_ENABLES;
            global_ie_q  <= 1'b0;
            conv_ie_q    <= 1'b0;
        end else if (wr_pending_q) begin
            if (hits(wr_addr_q, `OFS_CONTROL_A)) begin
                start_q     <= new_start;
                power_off_q <= hwdata_i[`BIT_POWER_OFF];
                chan_mid_q  <= hwdata_i[`BIT_CHAN_MID];
                chan_lo_q   <= hwdata_i[`BIT_CHAN_LO];
            end
            if (hits(wr_addr_q, `OFS_CONTROL_B)) begin
                chan_hi_q    <= hwdata_i[`BIT_CHAN_HI];
                ref_select_q <= hwdata_i[`BIT_REF_SELECT];
                divider_q    <= hwdata_i[`DIV_MSB:`DIV_LSB];
            end
            if (hits(wr_addr_q, `OFS_PIN_ENABLE_LOW)) begin
                pin_enable_q <= hwdata_i[3:0];
            end
            if (hits(wr_addr_q, `OFS_IRQ_CONTROL)) begin
                global_ie_q <= hwdata_i[`BIT_GLOBAL_IE];
                conv_ie_q   <= hwdata_i[`BIT_CONV_IE];
            end
        end
    end

    // Interrupt request flag: completion sets it, a write of zero clears it,
    // and a completion in the same cycle as the clear wins.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            conv_req_q <= 1'b0;
        end else if (finish) begin
            conv_req_q <= 1'b1;
        end else if (wr_pending_q && hits(wr_addr_q, `OFS_IRQ_CONTROL)) begin
            conv_req_q <= hwdata_i[`BIT_CONV_REQ];
        end
    end

    // Conversion sequencer. A rising start write holds the converter in reset
    // and raises pending; the following falling write launches the conversion.
    // A start while powered off is held and never launched, so pending stays
    // high until software powers on and repeats the sequence.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q   <= ST_IDLE;
            period_q  <= 5'h00;
            sar_q     <= 12'h000;
            bit_q     <= 4'h0;
            pending_q <= `RST_PENDING;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_wr && new_start && !start_q) begin
                        state_q   <= ST_HELD;
                        pending_q <= 1'b1;
                    end
                end
                ST_HELD: begin
                    period_q <= 5'h00;
                    if (begin_conv && !power_off_q) begin
                        state_q <= ST_CONV;
                        sar_q   <= 12'h800;
                        bit_q   <= 4'hb;
                    end else if (begin_conv) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_CONV: begin
                    if (start_wr && new_start) begin
                        // A new rising start aborts and holds in reset.
                        state_q  <= ST_HELD;
                        period_q <= 5'h00;
                    end else if (power_off_q) begin
                        state_q <= ST_IDLE;
                    end else if (conv_tick) begin
                        period_q <= period_q + 5'h01;
                        // Bit trials follow the sampling periods, MSB first.
                        if (period_q >= `SAMPLE_PERIODS
                            && period_q < `SAMPLE_PERIODS + 5'h0c) begin
                            if (!comp_q) begin
                                sar_q[bit_q] <= 1'b0;
                            end
                            if (bit_q != 4'h0) begin
                                sar_q[bit_q - 4'h1] <= 1'b1;
                                bit_q <= bit_q - 4'h1;
                            end
                        end
                        if (finish) begin
                            state_q   <= ST_IDLE;
                            pending_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Result is loaded only at completion, in the same edge that drops
    // pending, so software never sees pending low with a stale value.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            result_q <= 12'h000;
        end else if (finish) begin
            result_q <= sar_q;
        end
    end

    // Analog side controls, all from flops.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            analog_power_o   <= 1'b0;
            sample_track_o   <= 1'b0;
            dac_code_o       <= 12'h000;
            channel_select_o <= 3'h0;
            ref_from_pin_o   <= 1'b0;
            conv_irq_o       <= 1'b0;
        end else begin
            analog_power_o   <= !power_off_q;
            // Power-off gates sampling at once, so an aborted conversion never
            // tracks an input on an unpowered converter.
            sample_track_o   <= (state_q == ST_CONV) && !power_off_q
                                && (period_q < `SAMPLE_PERIODS);
            dac_code_o       <= sar_q;
            channel_select_o <= {chan_hi_q, chan_mid_q, chan_lo_q};
            ref_from_pin_o   <= ref_select_q;
            conv_irq_o       <= conv_req_q && global_ie_q && conv_ie_q;
        end
    end

endmodule

// >>> hdl/conv_clock_divider.v
`timescale 1ns/1ns
`include "adc_ctrl_defines.vh"

// Makes the conversion clock as a one-cycle enable pulse from the system clock.
module conv_clock_divider (
    // Clock and reset.
    input  wire       sys_clk_i,
    input  wire       rst_i,
    // Control.
    input  wire       restart_i,
    input  wire [2:0] divider_code_i,
    // Enable pulse.
    output reg        tick_o
);

    reg [6:0] count_q;   // Count of system clocks since the last tick or restart.
    reg [6:0] limit;     // Terminal count for the chosen ratio.

    // Code n divides by two to the n; the undefined top code behaves as divide by 64.
    always @* begin
        case (divider_code_i)
            3'h0:    limit = 7'h00;
            3'h1:    limit = 7'h01;
            3'h2:    limit = 7'h03;
            3'h3:    limit = 7'h07;
            3'h4:    limit = 7'h0f;
            3'h5:    limit = 7'h1f;
            default: limit = 7'h3f;
        endcase
    end

    // Restarting aligns the first period with the conversion start, so each
    // conversion lasts its full count of periods, the first one a system clock longer.
    always @(posedge sys_clk_i) begin
        if (rst_i || restart_i) begin
            count_q <= 7'h00;
            tick_o  <= 1'b0;
        end else if (count_q >= limit) begin
            count_q <= 7'h00;
            tick_o  <= 1'b1;
        end else begin
            count_q <= count_q + 7'h01;
            tick_o  <= 1'b0;
        end
    end

endmodule

// >>> hdl/pin_function_mux.v
`timescale 1ns/1ns

// Registered override of port pin functions by the analog input enables.
module pin_function_mux (
    // Clock and reset.
    input  wire       sys_clk_i,
    input  wire       rst_i,
    // Settings from the port and the converter.
    input  wire [3:0] analog_enable_i,
    input  wire [3:0] port_dir_input_i,
    input  wire [3:0] pullup_request_i,
    input  wire       ref_select_i,
    // Effective pin configuration.
    output reg  [3:0] pin_dir_input_o,
    output reg  [3:0] pin_pullup_o,
    output reg  [3:0] pin_digital_off_o,
    output reg        ref_pin_claim_o
);

    // One flop stage keeps every pin control glitch free.
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pin_dir_input_o   <= 4'hf;
            pin_pullup_o      <= 4'h0;
            pin_digital_off_o <= 4'hf;
            ref_pin_claim_o   <= 1'b0;
        end else begin
            pin_digital_off_o <= analog_enable_i;
            pin_dir_input_o   <= port_dir_input_i | analog_enable_i;
            pin_pullup_o      <= pullup_request_i & ~analog_enable_i;
            ref_pin_claim_o   <= ref_select_i;
        end
    end

endmodule

// >>> pkg/adc_ctrl_defines.vh
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// Register byte offsets on the AHB-Lite bus.
`define OFS_CONTROL_A       8'h00
`define OFS_CONTROL_B       8'h04
`define OFS_PIN_ENABLE_LOW  8'h08
`define OFS_RESULT_LOW      8'h0c
`define OFS_RESULT_HIGH     8'h10
`define OFS_IRQ_CONTROL     8'h14

// Field positions in converter_control_a.
`define BIT_START           7
`define BIT_PENDING         6
`define BIT_POWER_OFF       5
`define BIT_CHAN_MID        1
`define BIT_CHAN_LO         0

// Field positions in converter_control_b.
`define BIT_CHAN_HI         7
`define BIT_REF_SELECT      6
`define DIV_MSB             2
`define DIV_LSB             0

// Field positions in the interrupt control register.
`define BIT_GLOBAL_IE       0
`define BIT_CONV_IE         1
`define BIT_CONV_REQ        2

// Reset values.
`define RST_POWER_OFF       1'b1
`define RST_PIN_ENABLES     4'hf
`define RST_DIVIDER         3'h0
`define RST_PENDING         1'b0

// Timing counts in conversion clock periods, and the result width in bits.
`define CONV_PERIODS        5'h10
`define SAMPLE_PERIODS      5'h02
`define RESULT_BITS         12

// AHB-Lite transfer type for a new single transfer.
`define HTRANS_NONSEQ       2'h2

`endif
